// [rtl/pced_defs.vh]
// register map, field layout and reset values of the pin change detector
`ifndef PCED_DEFS_VH
`define PCED_DEFS_VH

`define PCED_AW 4
`define PCED_DW 32
`define PCED_PW 8
`define PCED_NPORT 3
`define PCED_RST8 8'h00
`define PCED_RST32 32'h0000_0000
`define PCED_ZERO24 24'h00_0000
`define PCED_ZERO29 29'h0000_0000

// word indexes; byte address is four times the index
`define PCED_REG_PA_RISE 4'h0
`define PCED_REG_PA_FALL 4'h1
`define PCED_REG_PA_FLAG 4'h2
`define PCED_REG_PB_RISE 4'h3
`define PCED_REG_PB_FALL 4'h4
`define PCED_REG_PB_FLAG 4'h5
`define PCED_REG_PC_RISE 4'h6
`define PCED_REG_PC_FALL 4'h7
`define PCED_REG_PC_FLAG 4'h8
`define PCED_REG_CTRL 4'h9
`define PCED_REG_STATUS 4'ha
`define PCED_REG_IRQ_CLR 4'hb
`define PCED_REG_IRQ_EN 4'hc

// control register: bit 0 master enable
`define PCED_CTRL_MASTER 0
// status / clear / enable layout: bit 0 port a, 1 port b, 2 port c change events
`define PCED_EVT_W 3

// port b pins withheld while the debugger owns them
`define PCED_DBG_MASK 8'h3f

`endif

// [rtl/pced_top.v]
// pin change edge detector for three 8-bit ports with avalon-mm register slave
// Behaviour
// - with master enable set a change event raises wake-up; otherwise no wake-up.
// - port a rise enable makes a rising edge set its flag and combined flag.
// - port a fall enable makes a falling edge set its flag and combined flag.
// - port a flag sets on rising edge when its rise enable is one.
// - port a flag sets on falling edge when its fall enable is one.
// - a set flag stays set until software writes it to zero; here debugger enable also clears port b flags 7 and 6.
// - port b rise enable makes a rising edge set its flag and combined flag.
// - port b fall enable makes a falling edge set its flag and combined flag.
// - port b flag sets on an enabled rising or falling edge.
// - with debugger enabled port b pins 7 and 6 take no part in detection.
// - port c rise enable makes a rising edge set its flag and combined flag.
// - port c fall enable makes a falling edge set its flag and combined flag.
// - an enable bit at zero leaves that edge ignored on that pin.
// - all enable and flag bits reset to zero on every reset.
// - flags are software readable and writable and set by hardware too.
// - detection and flags keep working while the master enable is clear.
// - combined flag is the or of every per-pin flag.
// - an edge arriving during a software clear leaves the flag set.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`include "pced_defs.vh"

module pced_top (
  input wire core_clk, // system clock, 10 MHz
  input wire srst, // synchronous reset, active high
  input wire [`PCED_AW-1:0] avs_address, // word index
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [`PCED_DW-1:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte enables; lane 0 carries the registers
  output reg [`PCED_DW-1:0] avs_readdata, // read data
  output reg avs_waitrequest, // stall
  input wire [`PCED_PW-1:0] porta_pin, // port a pin levels
  input wire [`PCED_PW-1:0] portb_pin, // port b pin levels
  input wire [`PCED_PW-1:0] portc_pin, // port c pin levels
  input wire debugger_enable, // debugger owns port b pins 7 and 6
  output reg combined_change_flag, // or of all per-pin flags
  output reg change_irq, // interrupt to the controller
  output reg wake_req, // wake-up from sleep
  output reg irq // level interrupt of the status block
);

////////////////////////////////////////////////////////////////////////////////
// register storage, indexed by port
reg [`PCED_PW-1:0] rise_en [0:`PCED_NPORT-1];
reg [`PCED_PW-1:0] fall_en [0:`PCED_NPORT-1];
reg [`PCED_PW-1:0] flags [0:`PCED_NPORT-1];
reg change_irq_master_enable;
reg [`PCED_EVT_W-1:0] evt_status;
reg [`PCED_EVT_W-1:0] evt_enable;

wire [`PCED_PW-1:0] pin_in [0:`PCED_NPORT-1];
assign pin_in[0] = porta_pin;
assign pin_in[1] = portb_pin;
assign pin_in[2] = portc_pin;

// port b upper pins drop out while the debugger holds them
wire [`PCED_PW-1:0] port_avail [0:`PCED_NPORT-1];
assign port_avail[0] = {`PCED_PW{1'b1}};
assign port_avail[1] = debugger_enable ? `PCED_DBG_MASK : {`PCED_PW{1'b1}};
assign port_avail[2] = {`PCED_PW{1'b1}};

// one-cycle bus answer: waitrequest drops the cycle after a request arrives
wire bus_req = (avs_read | avs_write) & avs_waitrequest;
wire wr_go = avs_write & ~avs_waitrequest;
wire rd_go = avs_read & ~avs_waitrequest;
wire lane0 = avs_byteenable[0];

// decoding used by every per-port register
function wr_hit;
  input [`PCED_AW-1:0] addr;
  input [`PCED_AW-1:0] idx;
  begin
    wr_hit = (addr == idx);
  end
endfunction

function [`PCED_AW-1:0] port_idx;
  input [1:0] port;
  input [1:0] kind;
  begin
    port_idx = (`PCED_REG_PA_RISE + {2'b00, port} * 4'h3 + {2'b00, kind});
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// per-port synchroniser, edge detect and flags
wire [`PCED_NPORT-1:0] port_event;
wire [`PCED_NPORT-1:0] port_any;

genvar gp;
generate
  for (gp = 0; gp < `PCED_NPORT; gp = gp + 1) begin : g_port
    reg [`PCED_PW-1:0] sync1;
    reg [`PCED_PW-1:0] sync2;
    reg [`PCED_PW-1:0] prev;
    wire [`PCED_PW-1:0] rise_hit;
    wire [`PCED_PW-1:0] fall_hit;
    wire [`PCED_PW-1:0] set_bits;
    wire flag_wr;
    reg [`PCED_PW-1:0] next_flags;

    always @(posedge core_clk) begin
      if (srst) begin
        sync1 <= `PCED_RST8;
        sync2 <= `PCED_RST8;
        prev <= `PCED_RST8;
      end else begin
        sync1 <= pin_in[gp];
        sync2 <= sync1;
        prev <= sync2;
      end
    end

    assign rise_hit = sync2 & ~prev & rise_en[gp];
    assign fall_hit = ~sync2 & prev & fall_en[gp];
    assign set_bits = (rise_hit | fall_hit) & port_avail[gp];
    assign flag_wr = wr_go & lane0 & wr_hit(avs_address, port_idx(gp, 2'd2));

    always @* begin
      next_flags = flags[gp];
      if (flag_wr)
        next_flags = avs_writedata[`PCED_PW-1:0];
      next_flags = (next_flags | set_bits) & port_avail[gp];
    end

    always @(posedge core_clk) begin
      if (srst) begin
        rise_en[gp] <= `PCED_RST8;
        fall_en[gp] <= `PCED_RST8;
        flags[gp] <= `PCED_RST8;
      end else begin
        if (wr_go & lane0 & wr_hit(avs_address, port_idx(gp, 2'd0)))
          rise_en[gp] <= avs_writedata[`PCED_PW-1:0] & port_avail[gp];
        if (wr_go & lane0 & wr_hit(avs_address, port_idx(gp, 2'd1)))
          fall_en[gp] <= avs_writedata[`PCED_PW-1:0] & port_avail[gp];
        // flags run regardless of master enable
        flags[gp] <= next_flags;
      end
    end

    assign port_event[gp] = |set_bits;
    assign port_any[gp] = |flags[gp];
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// control, event status and interrupt block
wire ctrl_wr = wr_go & lane0 & wr_hit(avs_address, `PCED_REG_CTRL);
wire clr_wr = wr_go & lane0 & wr_hit(avs_address, `PCED_REG_IRQ_CLR);
wire en_wr = wr_go & lane0 & wr_hit(avs_address, `PCED_REG_IRQ_EN);
wire any_flag = |port_any;
reg [`PCED_EVT_W-1:0] next_status;

always @* begin
  next_status = evt_status;
  if (clr_wr)
    next_status = next_status & ~avs_writedata[`PCED_EVT_W-1:0];
  // an event in the clearing cycle stays recorded
  next_status = next_status | port_event;
end

always @(posedge core_clk) begin
  if (srst) begin
    change_irq_master_enable <= 1'b0;
    evt_status <= {`PCED_EVT_W{1'b0}};
    evt_enable <= {`PCED_EVT_W{1'b0}};
    combined_change_flag <= 1'b0;
    change_irq <= 1'b0;
    wake_req <= 1'b0;
    irq <= 1'b0;
  end else begin
    if (ctrl_wr)
      change_irq_master_enable <= avs_writedata[`PCED_CTRL_MASTER];
    if (en_wr)
      evt_enable <= avs_writedata[`PCED_EVT_W-1:0];
    evt_status <= next_status;
    combined_change_flag <= any_flag;
    change_irq <= any_flag & change_irq_master_enable;
    wake_req <= any_flag & change_irq_master_enable;
    irq <= |(next_status & evt_enable);
  end
end

////////////////////////////////////////////////////////////////////////////////
// avalon-mm slave: one wait state on every access
reg [`PCED_DW-1:0] rd_mux;

always @* begin
  case (avs_address)
    `PCED_REG_PA_RISE: rd_mux = {`PCED_ZERO24, rise_en[0]};
    `PCED_REG_PA_FALL: rd_mux = {`PCED_ZERO24, fall_en[0]};
    `PCED_REG_PA_FLAG: rd_mux = {`PCED_ZERO24, flags[0]};
    `PCED_REG_PB_RISE: rd_mux = {`PCED_ZERO24, rise_en[1]};
    `PCED_REG_PB_FALL: rd_mux = {`PCED_ZERO24, fall_en[1]};
    `PCED_REG_PB_FLAG: rd_mux = {`PCED_ZERO24, flags[1]};
    `PCED_REG_PC_RISE: rd_mux = {`PCED_ZERO24, rise_en[2]};
    `PCED_REG_PC_FALL: rd_mux = {`PCED_ZERO24, fall_en[2]};
    `PCED_REG_PC_FLAG: rd_mux = {`PCED_ZERO24, flags[2]};
    `PCED_REG_CTRL: rd_mux = {`PCED_ZERO29, 2'b00, change_irq_master_enable};
    `PCED_REG_STATUS: rd_mux = {`PCED_ZERO29, evt_status};
    `PCED_REG_IRQ_EN: rd_mux = {`PCED_ZERO29, evt_enable};
    // clear register and unmapped words read as zero
    default: rd_mux = `PCED_RST32;
  endcase
end

always @(posedge core_clk) begin
  if (srst) begin
    avs_waitrequest <= 1'b1;
    avs_readdata <= `PCED_RST32;
  end else begin
    // low for exactly one cycle per request, then high again
    avs_waitrequest <= ~bus_req;
    // read data stands only in the answer cycle, zero whenever waitrequest is high
    if (bus_req & avs_read)
      avs_readdata <= rd_mux;
    else
      avs_readdata <= `PCED_RST32;
  end
end

endmodule

// [tb/pced_props.sv]
// port assertions and covers of the pin change detector
module pced_props (
  input logic core_clk, // clock
  input logic srst, // sync reset
  input logic avs_read, // read
  input logic avs_write, // write
  input logic avs_waitrequest, // stall
  input logic [31:0] avs_readdata, // read data
  input logic [7:0] porta_pin, // port a
  input logic [7:0] portb_pin, // port b
  input logic [7:0] portc_pin, // port c
  input logic combined_change_flag, // or of flags
  input logic change_irq, // change irq
  input logic wake_req, // wake-up
  input logic irq // status irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////
  a_wake_tracks: assert property (wake_req == change_irq) else $error("wake");
  a_irq_flag: assert property (change_irq |-> combined_change_flag) else $error("irq");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wr1");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("ans");
  a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0) else $error("rd");
  // software never sets a flag here, so a new flag needs a pin change five edges back
  a_edge_cause: assert property ($rose(combined_change_flag) |->
    $past(porta_pin, 5) != $past(porta_pin, 4) || $past(portb_pin, 5) != $past(portb_pin, 4)
    || $past(portc_pin, 5) != $past(portc_pin, 4)) else $error("cause");
  a_flag_sticky: assert property (combined_change_flag && !avs_write && !$past(avs_write)
    |=> combined_change_flag) else $error("sticky");
  a_reset_clear: assert property (disable iff (1'b0) srst |=> !combined_change_flag
    && !wake_req && !irq && avs_waitrequest) else $error("reset");
  c_wake: cover property ($rose(wake_req));
  c_irq: cover property ($rose(irq));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind pced_top pced_props u_props (.core_clk, .srst, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .porta_pin, .portb_pin, .portc_pin, .combined_change_flag, .change_irq,
  .wake_req, .irq);

// [tb/pced_pins.sv]
// far-side model: drives the three ports' pin levels
module pced_pins (
  input logic core_clk, // clock
  input logic [23:0] want, // levels asked for
  output logic [7:0] porta_pin, // port a
  output logic [7:0] portb_pin, // port b
  output logic [7:0] portc_pin // port c
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  initial {portc_pin, portb_pin, porta_pin} = 24'h0;
  // levels move only every other edge: narrower pulses may slip past the synchroniser
  always @(posedge core_clk) begin
    ph <= !ph;
    if (ph)
      {portc_pin, portb_pin, porta_pin} <= want;
  end
endmodule

// [tb/tb.sv]
// testbench of the pin change detector
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, avs_read = 0, avs_write = 0, debugger_enable = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, combined_change_flag, change_irq, wake_req, irq;
  logic [7:0] porta_pin, portb_pin, portc_pin, r;
  logic [23:0] want = 24'h0;
  logic [33:0] q[$];
  int seed = 32'h5d0f2470, n_errors = 0, tests_run = 0, cyc = 0;
  pced_top uut (.core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .porta_pin, .portb_pin, .portc_pin,
    .debugger_enable, .combined_change_flag, .change_irq, .wake_req, .irq);
  pced_pins far (.core_clk, .want, .porta_pin, .portb_pin, .portc_pin);
  always #50 core_clk = ~core_clk;
  ////////////////////////////////
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [33:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task rst_chk;
    srst <= 1'b1;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++)
      rd(4'(i), 34'h0); // zero after reset
  endtask
  ////////////////////////////////
  // outputs sampled at the completing edge, before that edge's updates land
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_errors++;
      end_sim();
    end
    if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0)
      chk({wake_req, irq, avs_readdata}, q.pop_front()); // readback
  end
  initial begin
    rst_chk();
    avs_byteenable <= 4'h0;
    bus(1'b1, 4'h0, 32'hff);
    avs_byteenable <= 4'hf;
    rd(4'h0, 34'h0); // write ignored
    bus(1'b1, 4'hc, 32'h7);
    for (int p = 0; p < 3; p++) begin
      r = 8'($random(seed));
      bus(1'b1, 4'h9, {31'h0, p != 0});
      bus(1'b1, 4'(3 * p), {24'h0, r});
      bus(1'b1, 4'(3 * p + 1), {24'h0, ~r});
      rd(4'(3 * p), {26'h0, r}); // enable readback
      want[8 * p +: 8] <= 8'hff;
      repeat (8) @(posedge core_clk);
      rd(4'(3 * p + 2), {p != 0 && r != 0, r != 0, 24'h0, r});
      // clear the whole flag register, then every status bit
      bus(1'b1, 4'(3 * p + 2), 32'h0);
      bus(1'b1, 4'hb, 32'h7);
      want[8 * p +: 8] <= 8'h00;
      repeat (8) @(posedge core_clk);
      rd(4'(3 * p + 2), {p != 0 && r != 8'hff, r != 8'hff, 24'h0, ~r});
      bus(1'b1, 4'(3 * p + 2), 32'h0);
      bus(1'b1, 4'hb, 32'h7);
      rd(4'ha, 34'h0); // all clear
    end
    debugger_enable <= 1'b1;
    bus(1'b1, 4'h3, 32'hff);
    rd(4'h3, 34'h3f); // masked enables
    want[15:8] <= 8'hff;
    repeat (8) @(posedge core_clk);
    rd(4'h5, {2'b11, 32'h3f}); // masked flags
    chk({32'h0, combined_change_flag, change_irq}, 34'h3);
    rst_chk();
    end_sim();
  end
endmodule
